// [inc/intr_pkg.sv]
// constants for the interrupt recognition and dispatch block
// assumes a 32-bit status word, word-aligned memory and a classic wishbone register port
package intr_pkg;
  // ==========================================================
  // status word layout
  localparam int PSW_ET_LSB = 0;
  localparam int PSW_TM_BIT = 2;
  localparam int PSW_ISC_LSB = 3;
  localparam int PSW_I_BIT = 7;
  localparam int PSW_R_BIT = 8;
  localparam int PSW_CM_LSB = 11;
  localparam int PSW_PM_LSB = 13;
  localparam int PSW_QS_BIT = 25;
  localparam logic [31:0] PSW_RST = 32'h0001e03b;
  localparam logic [3:0] PM_MAX = 4'hf;
  // ==========================================================
  // field values written by the sequences
  localparam logic [3:0] ISC_RUN = 4'h7;
  localparam logic TM_RUN = 1'b0;
  localparam logic [1:0] ET_RUN = 2'h3;
  localparam logic [3:0] ISC_SAVED = 4'h0;
  localparam logic TM_SAVED = 1'b0;
  localparam logic [1:0] ET_SAVED = 2'h1;
  // ==========================================================
  // exception classes and codes
  localparam logic [1:0] ET_RESET = 2'h0;
  localparam logic [1:0] ET_PROCESS = 2'h1;
  localparam logic [1:0] ET_STACK = 2'h2;
  localparam logic [1:0] ET_NORMAL = 2'h3;
  localparam logic [3:0] ISC_INT_STACK = 4'h1;
  localparam logic [3:0] ISC_OLD_CB = 4'h0;
  localparam logic [3:0] ISC_NEW_CB = 4'h1;
  localparam logic [3:0] ISC_ID_FETCH = 4'h0;
  localparam logic [3:0] ISC_GATE_VEC = 4'h7;
  localparam logic [3:0] ISC_PRIV_INS = 4'h8;
  localparam logic [3:0] ISC_PRIV_REG = 4'h9;
  // ==========================================================
  // memory map of the tables and the context block
  localparam logic [31:0] FULL_BASE = 32'h0000008c;
  localparam logic [31:0] QUICK_BASE = 32'h0000048c;
  localparam logic [31:0] NEST_STEP = 32'h00000004;
  localparam logic [31:0] PAIR_STEP = 32'h00000008;
  localparam logic [31:0] CB_PSW = 32'h00000000;
  localparam logic [31:0] CB_PC = 32'h00000004;
  localparam logic [31:0] CB_SP = 32'h00000008;
  localparam logic [31:0] CB_LO = 32'h0000000c;
  localparam logic [31:0] CB_HI = 32'h00000010;
  localparam logic [31:0] CB_SAVED = 32'h00000014;
  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_PSW = 8'h00;
  localparam logic [7:0] REG_CONTEXT_BLOCK_POINTER = 8'h04;
  localparam logic [7:0] REG_NSP = 8'h08;
  localparam logic [7:0] REG_PC = 8'h0c;
  localparam logic [7:0] REG_SP = 8'h10;
  localparam logic [7:0] REG_LO = 8'h14;
  localparam logic [7:0] REG_HI = 8'h18;
  localparam logic [7:0] REG_STAT = 8'h1c;
  // ==========================================================
  // memory cycle kinds and idle pin pattern {nmi_n, level, autovector_select_n_n, opt_n}
  localparam logic [1:0] KIND_DATA = 2'h0;
  localparam logic [1:0] KIND_INTACK = 2'h1;
  localparam logic [1:0] KIND_AUTOACK = 2'h2;
  localparam logic [6:0] PIN_IDLE = 7'h43;
  typedef enum logic [4:0] {
    ST_IDLE, ST_ACK, ST_PUSH_NSP, ST_SAVE_PSW, ST_SAVE_PC, ST_SAVE_SP, ST_GET_CBP,
    ST_LD_PSW, ST_LD_PC, ST_LD_SP, ST_LD_LO, ST_LD_HI, ST_Q_PUSH_PC, ST_Q_PUSH_PSW,
    ST_Q_LD_PSW, ST_Q_LD_PC, ST_RET_POP
  } seq_state_t;
endpackage : intr_pkg

// [design/intr_dispatch.sv]
// interrupt recognition, identifier formation and full/quick dispatch
// assumes a memory port that answers each request with ack or err, and pins asynchronous to mclk_i
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
module intr_dispatch #(
  parameter int ADR_W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic nonmaskable_request_n_i,
  input wire logic [3:0] request_level_pins_i,
  input wire logic autovector_select_n_i,
  input wire logic vector_option_n_i,
  input wire logic boundary_i,
  input wire logic process_call_op_i,
  input wire logic [31:0] call_pointer_i,
  input wire logic process_return_op_i,
  output logic mem_cyc_o,
  output logic mem_we_o,
  output logic [31:0] mem_adr_o,
  output logic [31:0] mem_dat_o,
  output logic [1:0] mem_kind_o,
  input wire logic [31:0] mem_dat_i,
  input wire logic mem_ack_i,
  input wire logic mem_err_i,
  output logic busy_o,
  output logic kernel_force_o,
  output logic [7:0] int_id_o,
  output logic exc_valid_o,
  output logic [1:0] exc_type_o,
  output logic [3:0] exc_isc_o
);
  if (ADR_W < 5) begin : g_bad_adr
    $error("ADR_W too small for the register map");
  end
  // ==========================================================
  // architectural registers
  intr_pkg::seq_state_t state;
  logic [31:0] processor_status_word, context_block_pointer, nesting_stack_pointer, pc, sp, stk_lo, stk_hi, tempa;
  logic [7:0] id;
  logic took_nmi, calling;
  logic [6:0] sync1, sync2, sync3, pins;
  // ==========================================================
  // pin synchronisers
  // three flops, then a filter that passes a change only when two successive samples agree
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sync1 <= intr_pkg::PIN_IDLE;
      sync2 <= intr_pkg::PIN_IDLE;
      sync3 <= intr_pkg::PIN_IDLE;
      pins <= intr_pkg::PIN_IDLE;
    end else begin
      sync1 <= {nonmaskable_request_n_i, request_level_pins_i, autovector_select_n_i, vector_option_n_i};
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        pins <= sync3;
      end
    end
  end
  // ==========================================================
  // recognition
  wire nmi_req = ~pins[6];
  wire [3:0] level = pins[5:2];
  wire autovector_select_n = ~pins[1];
  wire opt = ~pins[0];
  wire [3:0] pmask = processor_status_word[intr_pkg::PSW_PM_LSB +: 4];
  wire kernel = processor_status_word[intr_pkg::PSW_CM_LSB +: 2] == 2'h0;
  wire quick = processor_status_word[intr_pkg::PSW_QS_BIT];
  wire idle = state == intr_pkg::ST_IDLE;
  // strict compare; mask 15 leaves nothing above it
  wire mask_req = level > pmask;
  // nonmaskable first, only at a boundary
  wire take = idle & boundary_i & (nmi_req | mask_req);
  wire [7:0] auto_id = {3'h0, opt, level};
  wire done = mem_cyc_o & mem_ack_i;
  wire fail = mem_cyc_o & mem_err_i;
  wire [31:0] id_x4 = {22'h0, id, 2'h0};
  wire [31:0] id_x8 = {21'h0, id, 3'h0};
  // ==========================================================
  // memory step decode
  logic need_mem, step_we;
  logic [31:0] step_adr, step_dat;
  logic [1:0] step_kind, exc_et;
  logic [3:0] exc_code;
  always_comb begin
    need_mem = 1'b1;
    step_we = 1'b0;
    step_adr = 32'h0;
    step_dat = 32'h0;
    step_kind = intr_pkg::KIND_DATA;
    exc_et = intr_pkg::ET_PROCESS;
    exc_code = intr_pkg::ISC_NEW_CB;
    unique case (state)
      intr_pkg::ST_IDLE: need_mem = 1'b0;
      intr_pkg::ST_ACK: begin
        step_kind = (took_nmi | autovector_select_n) ? intr_pkg::KIND_AUTOACK : intr_pkg::KIND_INTACK;
        step_adr = {28'h0, level};
        exc_et = intr_pkg::ET_STACK;
        exc_code = intr_pkg::ISC_ID_FETCH;
      end
      intr_pkg::ST_PUSH_NSP, intr_pkg::ST_RET_POP: begin
        step_we = state == intr_pkg::ST_PUSH_NSP;
        step_adr = step_we ? nesting_stack_pointer : nesting_stack_pointer - intr_pkg::NEST_STEP;
        step_dat = context_block_pointer;
        exc_et = intr_pkg::ET_RESET;
        exc_code = intr_pkg::ISC_INT_STACK;
      end
      intr_pkg::ST_SAVE_PSW, intr_pkg::ST_SAVE_PC, intr_pkg::ST_SAVE_SP: begin
        // pointer already addresses the save area
        step_we = 1'b1;
        exc_code = intr_pkg::ISC_OLD_CB;
        if (state == intr_pkg::ST_SAVE_PSW) begin
          step_adr = context_block_pointer + intr_pkg::CB_PSW;
          step_dat = set_fields(processor_status_word, intr_pkg::ISC_SAVED, intr_pkg::TM_SAVED, intr_pkg::ET_SAVED);
        end else if (state == intr_pkg::ST_SAVE_PC) begin
          step_adr = context_block_pointer + intr_pkg::CB_PC;
          step_dat = pc;
        end else begin
          step_adr = context_block_pointer + intr_pkg::CB_SP;
          step_dat = sp;
        end
      end
      intr_pkg::ST_GET_CBP: step_adr = intr_pkg::FULL_BASE + id_x4;
      // only status word, pc, sp and bounds
      intr_pkg::ST_LD_PSW: step_adr = tempa + intr_pkg::CB_PSW;
      intr_pkg::ST_LD_PC: step_adr = tempa + intr_pkg::CB_PC;
      intr_pkg::ST_LD_SP: step_adr = tempa + intr_pkg::CB_SP;
      intr_pkg::ST_LD_LO: step_adr = tempa + intr_pkg::CB_LO;
      intr_pkg::ST_LD_HI: step_adr = tempa + intr_pkg::CB_HI;
      intr_pkg::ST_Q_PUSH_PC, intr_pkg::ST_Q_PUSH_PSW: begin
        step_we = 1'b1;
        step_adr = (state == intr_pkg::ST_Q_PUSH_PC) ? sp : sp + intr_pkg::NEST_STEP;
        step_dat = (state == intr_pkg::ST_Q_PUSH_PC) ? pc : processor_status_word;
        exc_et = intr_pkg::ET_NORMAL;
        exc_code = intr_pkg::ISC_GATE_VEC;
      end
      intr_pkg::ST_Q_LD_PSW, intr_pkg::ST_Q_LD_PC: begin
        step_adr = intr_pkg::QUICK_BASE + id_x8 + ((state == intr_pkg::ST_Q_LD_PC) ? 32'h4 : 32'h0);
        exc_et = intr_pkg::ET_NORMAL;
        exc_code = intr_pkg::ISC_GATE_VEC;
      end
    endcase
  end
  function automatic logic [31:0] set_fields(input logic [31:0] w, input logic [3:0] internal_state_field,
                                             input logic tm, input logic [1:0] et);
    logic [31:0] r;
    r = w;
    r[intr_pkg::PSW_ISC_LSB +: 4] = internal_state_field;
    r[intr_pkg::PSW_TM_BIT] = tm;
    r[intr_pkg::PSW_ET_LSB +: 2] = et;
    return r;
  endfunction : set_fields
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge
  // ==========================================================
  // register port decode
  wire [7:0] reg_adr = 8'(wb_adr_i);
  wire wb_req = wb_cyc_i & wb_stb_i;
  wire wr_go = wb_req & wb_we_i & wb_ack_o & idle;
  wire nsp_wr = wr_go & (reg_adr == intr_pkg::REG_NSP);
  wire priv_fail = nsp_wr & ~kernel;
  wire ret_priv = idle & ~take & process_return_op_i & ~kernel;
  logic [31:0] rd_mux;
  always_comb begin
    unique case (reg_adr)
      intr_pkg::REG_PSW: rd_mux = processor_status_word;
      intr_pkg::REG_CONTEXT_BLOCK_POINTER: rd_mux = context_block_pointer;
      intr_pkg::REG_NSP: rd_mux = nesting_stack_pointer;
      intr_pkg::REG_PC: rd_mux = pc;
      intr_pkg::REG_SP: rd_mux = sp;
      intr_pkg::REG_LO: rd_mux = stk_lo;
      intr_pkg::REG_HI: rd_mux = stk_hi;
      intr_pkg::REG_STAT: rd_mux = {23'h0, ~idle, id};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      if (wb_req & ~wb_ack_o) begin
        wb_dat_o <= wb_we_i ? 32'h0 : rd_mux;
      end
    end
  end
  // ==========================================================
  // memory request and exception outputs
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mem_cyc_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_adr_o <= 32'h0;
      mem_dat_o <= 32'h0;
      mem_kind_o <= intr_pkg::KIND_DATA;
      exc_valid_o <= 1'b0;
      exc_type_o <= intr_pkg::ET_RUN;
      exc_isc_o <= 4'h0;
    end else begin
      if (mem_cyc_o) begin
        mem_cyc_o <= ~(mem_ack_i | mem_err_i);
      end else if (need_mem) begin
        mem_cyc_o <= 1'b1;
        mem_we_o <= step_we;
        mem_adr_o <= step_adr;
        mem_dat_o <= step_dat;
        mem_kind_o <= step_kind;
      end
      exc_valid_o <= fail | priv_fail | ret_priv;
      if (fail) begin
        exc_type_o <= exc_et;
        exc_isc_o <= exc_code;
      end else if (priv_fail | ret_priv) begin
        exc_type_o <= intr_pkg::ET_NORMAL;
        exc_isc_o <= priv_fail ? intr_pkg::ISC_PRIV_REG : intr_pkg::ISC_PRIV_INS;
      end
    end
  end
  // ==========================================================
  // dispatch sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= intr_pkg::ST_IDLE;
      processor_status_word <= intr_pkg::PSW_RST;
      context_block_pointer <= 32'h0;
      nesting_stack_pointer <= 32'h0;
      pc <= 32'h0;
      sp <= 32'h0;
      stk_lo <= 32'h0;
      stk_hi <= 32'h0;
      tempa <= 32'h0;
      id <= 8'h0;
      took_nmi <= 1'b0;
      calling <= 1'b0;
    end else if (fail) begin
      state <= intr_pkg::ST_IDLE;
    end else begin
      unique case (state)
        intr_pkg::ST_IDLE: begin
          if (take) begin
            took_nmi <= nmi_req;
            calling <= 1'b0;
            state <= intr_pkg::ST_ACK;
          end else if (process_return_op_i & kernel) begin
            state <= intr_pkg::ST_RET_POP;
          end else if (process_call_op_i & kernel) begin
            calling <= 1'b1;
            tempa <= call_pointer_i;
            state <= intr_pkg::ST_PUSH_NSP;
          end else if (wr_go & ~priv_fail) begin
            if (reg_adr == intr_pkg::REG_PSW) processor_status_word <= merge(processor_status_word, wb_dat_i, wb_sel_i);
            if (reg_adr == intr_pkg::REG_CONTEXT_BLOCK_POINTER) context_block_pointer <= merge(context_block_pointer, wb_dat_i, wb_sel_i);
            if (nsp_wr) nesting_stack_pointer <= merge(nesting_stack_pointer, wb_dat_i, wb_sel_i);
            if (reg_adr == intr_pkg::REG_PC) pc <= merge(pc, wb_dat_i, wb_sel_i);
            if (reg_adr == intr_pkg::REG_SP) sp <= merge(sp, wb_dat_i, wb_sel_i);
          end
        end
        intr_pkg::ST_ACK: if (done) begin
          id <= took_nmi ? 8'h0 : (autovector_select_n ? auto_id : mem_dat_i[7:0]);
          state <= quick ? intr_pkg::ST_Q_PUSH_PC : intr_pkg::ST_PUSH_NSP;
        end
        intr_pkg::ST_PUSH_NSP: if (done) begin
          nesting_stack_pointer <= nesting_stack_pointer + intr_pkg::NEST_STEP;
          state <= intr_pkg::ST_SAVE_PSW;
        end
        intr_pkg::ST_SAVE_PSW: if (done) state <= intr_pkg::ST_SAVE_PC;
        intr_pkg::ST_SAVE_PC: if (done) state <= intr_pkg::ST_SAVE_SP;
        intr_pkg::ST_SAVE_SP: if (done) state <= calling ? intr_pkg::ST_LD_PSW : intr_pkg::ST_GET_CBP;
        intr_pkg::ST_GET_CBP: if (done) begin
          tempa <= mem_dat_i;
          state <= intr_pkg::ST_LD_PSW;
        end
        intr_pkg::ST_RET_POP: if (done) begin
          // pop without saving the exiting handler
          nesting_stack_pointer <= nesting_stack_pointer - intr_pkg::NEST_STEP;
          tempa <= mem_dat_i;
          state <= intr_pkg::ST_LD_PSW;
        end
        intr_pkg::ST_LD_PSW: if (done) begin
          processor_status_word <= mem_dat_i;
          state <= intr_pkg::ST_LD_PC;
        end
        intr_pkg::ST_LD_PC: if (done) begin
          pc <= mem_dat_i;
          state <= intr_pkg::ST_LD_SP;
        end
        intr_pkg::ST_LD_SP: if (done) begin
          sp <= mem_dat_i;
          state <= intr_pkg::ST_LD_LO;
        end
        intr_pkg::ST_LD_LO: if (done) begin
          stk_lo <= mem_dat_i;
          state <= intr_pkg::ST_LD_HI;
        end
        intr_pkg::ST_LD_HI: if (done) begin
          stk_hi <= mem_dat_i;
          // leave initial context for the save area
          context_block_pointer <= processor_status_word[intr_pkg::PSW_I_BIT] ? tempa + intr_pkg::CB_SAVED : tempa;
          processor_status_word <= set_fields(processor_status_word & ~(32'h1 << intr_pkg::PSW_I_BIT), intr_pkg::ISC_RUN, intr_pkg::TM_RUN,
                            intr_pkg::ET_RUN);
          state <= intr_pkg::ST_IDLE;
        end
        intr_pkg::ST_Q_PUSH_PC: if (done) state <= intr_pkg::ST_Q_PUSH_PSW;
        intr_pkg::ST_Q_PUSH_PSW: if (done) begin
          sp <= sp + intr_pkg::PAIR_STEP;
          state <= intr_pkg::ST_Q_LD_PSW;
        end
        intr_pkg::ST_Q_LD_PSW: if (done) begin
          // quick gate masks all maskable requests
          processor_status_word <= {mem_dat_i[31:intr_pkg::PSW_PM_LSB+4], intr_pkg::PM_MAX, mem_dat_i[intr_pkg::PSW_PM_LSB-1:0]};
          state <= intr_pkg::ST_Q_LD_PC;
        end
        intr_pkg::ST_Q_LD_PC: if (done) begin
          pc <= mem_dat_i;
          state <= intr_pkg::ST_IDLE;
        end
      endcase
    end
  end
  assign busy_o = ~idle;
  assign int_id_o = id;
  assign kernel_force_o = ~idle & state != intr_pkg::ST_Q_PUSH_PC & state != intr_pkg::ST_Q_PUSH_PSW;
  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  chk_mask_below: assert property (idle & boundary_i & ~nmi_req & level <= pmask & ~process_return_op_i
    & ~process_call_op_i |=> idle) else $error("maskable request taken at or below mask");
  chk_mask_full: assert property (idle & boundary_i & pmask == intr_pkg::PM_MAX & ~nmi_req
    |=> state != intr_pkg::ST_ACK) else $error("request taken with mask 15");
  chk_nmi_id: assert property (state == intr_pkg::ST_ACK & took_nmi & done ##1 1
    |-> id == 8'h0) else $error("nonmaskable identifier not zero");
  chk_auto_id: assert property (state == intr_pkg::ST_ACK & ~took_nmi & autovector_select_n & done
    |=> id == $past(auto_id)) else $error("autovector identifier wrong");
  chk_full_addr: assert property (state == intr_pkg::ST_GET_CBP & mem_cyc_o
    |-> mem_adr_o == intr_pkg::FULL_BASE + id_x4) else $error("full table address wrong");
  chk_quick_addr: assert property (state == intr_pkg::ST_Q_LD_PSW & mem_cyc_o
    |-> mem_adr_o == intr_pkg::QUICK_BASE + id_x8) else $error("quick table address wrong");
  chk_nest_push: assert property (state == intr_pkg::ST_PUSH_NSP & done & ~fail
    |=> nesting_stack_pointer == $past(nesting_stack_pointer) + 32'h4) else $error("nest push step");
  chk_quick_mask: assert property (state == intr_pkg::ST_Q_LD_PSW & done & ~fail
    |=> pmask == intr_pkg::PM_MAX ##1 1) else $error("quick mask not 15");
  chk_priv_write: assert property (priv_fail |=> exc_valid_o & exc_isc_o == intr_pkg::ISC_PRIV_REG
    & $stable(nesting_stack_pointer)) else $error("privileged write not refused");
  chk_run_fields: assert property (state == intr_pkg::ST_LD_HI & done & ~fail
    |=> processor_status_word[intr_pkg::PSW_ISC_LSB +: 4] == 4'h7 & ~processor_status_word[intr_pkg::PSW_TM_BIT]
    & processor_status_word[1:0] == 2'h3 & ~processor_status_word[intr_pkg::PSW_I_BIT]) else $error("final fields wrong");
  cov_full: cover property (state == intr_pkg::ST_GET_CBP & done);
  cov_quick: cover property (state == intr_pkg::ST_Q_LD_PC & done);
  cov_return: cover property (state == intr_pkg::ST_RET_POP & done);
  cov_nmi: cover property (take & nmi_req & quick);
endmodule : intr_dispatch

// [tb/mem_responder.sv]
// memory and acknowledge responder on the far side of the dispatch block
// assumes the block holds each request until it sees ack or err
`timescale 1ns/1ps
module mem_responder #(
  parameter int DLY = 2
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic mem_cyc_i,
  input wire logic [1:0] mem_kind_i,
  input wire logic [7:0] id_i,
  input wire logic err_i,
  output logic [31:0] mem_dat_o,
  output logic mem_ack_o,
  output logic mem_err_o
);
  int cnt;
  logic bad;
  logic [31:0] word;
  // ==========================================================
  // answer after DLY+1 wait cycles
  // fault only on identifier cycles
  assign bad = err_i && mem_kind_i != intr_pkg::KIND_DATA;
  assign word = mem_kind_i == intr_pkg::KIND_INTACK ? {24'h000000, id_i} : 32'h00000000;
  assign mem_dat_o = mem_ack_o ? word : ~word;
  always_ff @(posedge mclk_i) begin
    if (rst_i || !mem_cyc_i || mem_ack_o || mem_err_o) begin
      cnt <= 0;
      mem_ack_o <= 1'b0;
      mem_err_o <= 1'b0;
    end else if (cnt == DLY) begin
      mem_ack_o <= !bad;
      mem_err_o <= bad;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : mem_responder

// [tb/cpu_interrupt_recognition_dispatch_tb_top.sv]
// self-checking bench for the interrupt dispatch block
// assumes a zero-filled memory behind mem_responder
`timescale 1ns/1ps
module cpu_interrupt_recognition_dispatch_tb_top;
  logic mclk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd, vec, mem_adr_o, mem_dat_o, mem_dat_i;
  logic nonmaskable_request_n_i = 1'b1, autovector_select_n_i = 1'b1, vector_option_n_i = 1'b1;
  logic [3:0] request_level_pins_i = 4'h0, exc_isc_o;
  logic process_return_op_i = 1'b0, err_i = 1'b0, wb_ack_o, mem_cyc_o, mem_we_o, mem_ack_i, mem_err_i;
  logic boundary_i = 1'b1, process_call_op_i = 1'b0, kernel_force_o, was_busy = 1'b0;
  logic busy_o, exc_valid_o;
  logic [1:0] mem_kind_o, exc_type_o;
  logic [7:0] int_id_o;
  int fail_count = 0, checked = 0, kf_low, wr_n = 0;
  intr_dispatch u_dut (.mclk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .nonmaskable_request_n_i, .request_level_pins_i,
    .autovector_select_n_i, .vector_option_n_i, .boundary_i, .process_call_op_i,
    .call_pointer_i(32'h00000000), .process_return_op_i, .mem_cyc_o, .mem_we_o, .mem_adr_o,
    .mem_dat_o, .mem_kind_o, .mem_dat_i, .mem_ack_i, .mem_err_i, .busy_o, .kernel_force_o,
    .int_id_o, .exc_valid_o, .exc_type_o, .exc_isc_o);
  mem_responder u_mem (.mclk_i, .rst_i, .mem_cyc_i(mem_cyc_o), .mem_kind_i(mem_kind_o),
    .id_i(8'h42), .err_i, .mem_dat_o(mem_dat_i), .mem_ack_o(mem_ack_i), .mem_err_o(mem_err_i));
  always #4 mclk_i = ~mclk_i;
  // ==========================================================
  // first table read and cycles without forced kernel level of each sequence, plus a running count of writes since reset
  always @(posedge mclk_i) begin
    was_busy <= busy_o;
    if (busy_o && !was_busy) begin
      vec <= 32'h00000000;
      kf_low <= 0;
    end else begin
      if (mem_cyc_o && mem_ack_i && !mem_we_o && mem_adr_o >= 32'h0000008c && mem_adr_o < 32'h00001000
          && vec === 32'h00000000) vec <= mem_adr_o;
      if (busy_o && !kernel_force_o) kf_low <= kf_low + 1;
    end
    if (mem_cyc_o && mem_ack_i && mem_we_o) wr_n <= wr_n + 1;
  end
  task automatic end_of_test;
    if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("Error %0t got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
  endtask : wb
  task automatic go;
    while (busy_o !== 1'b1) @(posedge mclk_i);
    nonmaskable_request_n_i <= 1'b1; request_level_pins_i <= 4'h0; autovector_select_n_i <= 1'b1;
    vector_option_n_i <= 1'b1; process_return_op_i <= 1'b0; process_call_op_i <= 1'b0;
    while (busy_o !== 1'b0) @(posedge mclk_i);
    repeat (6) @(posedge mclk_i);
  endtask : go
  task automatic irq(input logic nm, input logic [3:0] lv, input logic av, input logic op);
    @(posedge mclk_i);
    nonmaskable_request_n_i <= nm; request_level_pins_i <= lv;
    autovector_select_n_i <= av; vector_option_n_i <= op;
    go();
  endtask : irq
  initial begin
    int w;
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 0); chk(rd, intr_pkg::PSW_RST);
    wb(1'b1, 8'h08, 32'h00002000);
    request_level_pins_i <= 4'hf;
    repeat (20) @(posedge mclk_i); chk(busy_o, 0);
    irq(1'b0, 4'h0, 1'b1, 1'b1); chk(int_id_o, 0); chk(vec, 32'h0000008c);
    chk(kf_low, 0);
    wb(1'b0, 8'h08, 0); chk(rd, 32'h00002004);
    wb(1'b0, 8'h00, 0); chk(rd[6:0], 7'h3b);
    wb(1'b1, 8'h00, 32'h02006000);
    irq(1'b1, 4'h5, 1'b0, 1'b0); chk(int_id_o, 32'h15); chk(vec, 32'h00000534);
    chk(kf_low, 10);
    wb(1'b0, 8'h00, 0); chk(rd[16:13], 4'hf);
    wb(1'b1, 8'h00, 32'h0000a000);
    request_level_pins_i <= 4'h5;
    repeat (20) @(posedge mclk_i); chk(busy_o, 0);
    irq(1'b1, 4'h6, 1'b1, 1'b1); chk(int_id_o, 32'h42); chk(vec, 32'h00000194);
    wb(1'b0, 8'h08, 0); chk(rd, 32'h00002008);
    process_return_op_i <= 1'b1;
    w = wr_n;
    go(); wb(1'b0, 8'h08, 0); chk(rd, 32'h00002004);
    chk(wr_n, w);
    wb(1'b1, 8'h00, 32'h00000000); err_i <= 1'b1;
    irq(1'b1, 4'h3, 1'b1, 1'b1); chk(exc_type_o, 2'h2); chk(exc_isc_o, 0);
    err_i <= 1'b0;
    wb(1'b1, 8'h00, 32'h0001f800); wb(1'b1, 8'h08, 0);
    @(posedge mclk_i); chk(exc_valid_o, 1);
    chk(exc_type_o, 2'h3); chk(exc_isc_o, 4'h9);
    wb(1'b0, 8'h08, 0); chk(rd, 32'h00002004);
    boundary_i <= 1'b0; nonmaskable_request_n_i <= 1'b0;
    repeat (20) @(posedge mclk_i); chk(busy_o, 0);
    boundary_i <= 1'b1;
    go(); chk(int_id_o, 0);
    process_call_op_i <= 1'b1;
    go(); wb(1'b0, 8'h08, 0); chk(rd, 32'h0000200c);
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    end_of_test();
  end
endmodule : cpu_interrupt_recognition_dispatch_tb_top
